// ---- pkg/cfc_params.svh ----
// Constants for the cascade frame counter block
`ifndef CFC_PARAMS_SVH
`define CFC_PARAMS_SVH
`define CFC_WORD_BITS 16
`define CFC_CHAIN_RESET 3'h0
`define CFC_RATE_RESET 2'h3
`define CFC_MCLK_DIV_RESET 3'h0
`define CFC_SCLK_HALF 3'h4
`define CFC_BIT_LAST 4'hf
`define CFC_FRAME_BITS 5'h10
`define CFC_FRAME_SAT 4'h8
`define CFC_PERIOD_BASE 12'h100
`define CFC_FACTOR_BASE 9'h020
`define CFC_SHIFT_BASE 4'h5
`define CFC_MOD_LAST 3'h7
`endif

// ---- pkg/cfc_pkg.sv ----
// Types for the cascade frame counter block
package cfc_pkg;
	typedef logic [1:0] cfc_rate_t;
	typedef logic [2:0] cfc_count_t;
	typedef logic [15:0] cfc_word_t;
	typedef enum {CFC_OUT_IDLE, CFC_OUT_FS, CFC_OUT_SHIFT} cfc_out_state_t;
endpackage

// ---- hw/cfc_mclk_div.sv ----
// Master clock divider producing the divided master clock tick
`timescale 1ns/100ps
`include "cfc_params.svh"
module cfc_mclk_div
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Divide code, ratio is code plus one
	input wire cfc_pkg::cfc_count_t i_div_code,
	// Divided master clock tick
	output logic o_tick
);
	import cfc_pkg::*;

	cfc_count_t cnt;
	cfc_count_t next_cnt;
	logic next_tick;

	// Count up to the divide code and pulse at the wrap
	always_comb
	begin
		if (cnt >= i_div_code)
		begin
			next_cnt = 3'h0;
			next_tick = 1'b1;
		end
		else
		begin
			next_cnt = cnt + 3'h1;
			next_tick = 1'b0;
		end
	end

	// Register divider state
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cnt <= 3'h0;
			o_tick <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			o_tick <= next_tick;
		end
	end
endmodule

// ---- hw/cfc_frame_counter.sv ----
// Codec serial port with cascade frame counting, decimator and interpolator
//
// Contract
// RQ1 - At most eight units counted per period
// RQ2 - Frames addressed only by position in period
// RQ3 - Controller keeps chain bits within serial clock
// RQ4 - Sample interval is M divided clock periods
// RQ5 - Controller sends whole chain within interval
// RQ6 - Output word takes sixteen serial clocks
// RQ7 - Load DAC when frame count matches
// RQ8 - Three-bit chain length field, resets zero
// RQ9 - Controller programs chain length minus one
// RQ10 - Chain length field decoded as plain binary
// RQ11 - Four selectable output sample rates
// RQ12 - Decimation factor 32 to 256 by rate
// RQ13 - DAC interpolates to divided clock over eight
// RQ14 - Master clock divider resets to one
// RQ15 - Interpolator bypass option
// RQ16 - Third-order sinc decimation filter
// RQ17 - Frame sync one clock before word
// RQ18 - Default rate divided clock over 2048
// RQ19 - Frame counter restarts each sample period
`timescale 1ns/100ps
`include "cfc_params.svh"
module cfc_frame_counter
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Configuration
	input wire cfc_pkg::cfc_count_t i_chain_length_field,
	input wire logic i_chain_length_we,
	input wire cfc_pkg::cfc_rate_t i_rate_sel,
	input wire logic i_rate_we,
	input wire cfc_pkg::cfc_count_t i_mclk_div_code,
	input wire logic i_mclk_div_we,
	input wire logic i_mode_data,
	input wire logic i_mode_mixed,
	input wire logic i_interp_bypass,
	// Modulator bit stream from the ADC
	input wire logic i_adc_mod_bit,
	// Serial pins from the controller
	input wire logic i_sdi,
	input wire logic i_input_frame_sync,
	// Serial pins to the controller
	output logic o_sclk,
	output logic o_sdo,
	output logic o_output_frame_sync,
	// Received words
	output cfc_pkg::cfc_word_t o_dac_word,
	output logic o_dac_load,
	output cfc_pkg::cfc_word_t o_ctrl_word,
	output logic o_ctrl_valid,
	// Converter side
	output cfc_pkg::cfc_word_t o_adc_word,
	output cfc_pkg::cfc_word_t o_dac_out,
	output logic o_sample_tick,
	output logic o_mod_tick,
	output logic [8:0] o_decim_factor
);
	import cfc_pkg::*;

	// Configuration registers
	cfc_count_t chain, next_chain, mdiv, next_mdiv;
	cfc_rate_t rate, next_rate, rate_eff;
	logic rate_prog, next_rate_prog;

	always_comb
	begin
		// RQ8 chain length store
		next_chain = i_chain_length_we ? i_chain_length_field : chain;
		next_rate = i_rate_we ? i_rate_sel : rate;
		next_rate_prog = rate_prog | i_rate_we;
		next_mdiv = i_mclk_div_we ? i_mclk_div_code : mdiv;
		// RQ18 default rate until programmed
		rate_eff = rate_prog ? rate : `CFC_RATE_RESET;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			chain <= `CFC_CHAIN_RESET;
			rate <= `CFC_RATE_RESET;
			rate_prog <= 1'b0;
			// RQ14 divide by one at reset
			mdiv <= `CFC_MCLK_DIV_RESET;
		end
		else
		begin
			chain <= next_chain;
			rate <= next_rate;
			rate_prog <= next_rate_prog;
			mdiv <= next_mdiv;
		end
	end

	// RQ14 converter timing from divider
	logic dm_tick;
	cfc_mclk_div u_div
	(
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_div_code(mdiv),
		.o_tick(dm_tick)
	);

	// Pin synchronisers, value changes when stages two and three agree
	logic [2:0] fs_sync, sdi_sync, next_fs_sync, next_sdi_sync;
	logic fs_f, sdi_f, next_fs_f, next_sdi_f;

	always_comb
	begin
		next_fs_sync = {fs_sync[1:0], i_input_frame_sync};
		next_sdi_sync = {sdi_sync[1:0], i_sdi};
		next_fs_f = (fs_sync[1] == fs_sync[2]) ? fs_sync[2] : fs_f;
		next_sdi_f = (sdi_sync[1] == sdi_sync[2]) ? sdi_sync[2] : sdi_f;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			fs_sync <= 3'h0;
			sdi_sync <= 3'h0;
			fs_f <= 1'b0;
			sdi_f <= 1'b0;
		end
		else
		begin
			fs_sync <= next_fs_sync;
			sdi_sync <= next_sdi_sync;
			fs_f <= next_fs_f;
			sdi_f <= next_sdi_f;
		end
	end

	// Serial clock generation with edge ticks
	logic [2:0] half, next_half;
	logic next_sclk, rise, fall, next_rise, next_fall;

	always_comb
	begin
		next_half = half + 3'h1;
		next_sclk = o_sclk;
		next_rise = 1'b0;
		next_fall = 1'b0;
		if (half == `CFC_SCLK_HALF - 3'h1)
		begin
			next_half = 3'h0;
			next_sclk = ~o_sclk;
			next_rise = ~o_sclk;
			next_fall = o_sclk;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			half <= 3'h0;
			o_sclk <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end
		else
		begin
			half <= next_half;
			o_sclk <= next_sclk;
			rise <= next_rise;
			fall <= next_fall;
		end
	end

	// Sample period counter
	logic [10:0] pcnt, next_pcnt, limit;
	logic sample_evt, mod_evt;
	logic [3:0] sh;

	always_comb
	begin
		// RQ4 period of M divided clocks
		limit = 11'((`CFC_PERIOD_BASE << rate_eff) - 12'h001);
		// RQ11 rate select sets interval
		sample_evt = dm_tick && (pcnt == limit);
		// RQ13 modulator tick every eight
		mod_evt = dm_tick && (pcnt[2:0] == `CFC_MOD_LAST);
		sh = `CFC_SHIFT_BASE + {2'h0, rate_eff};
		next_pcnt = pcnt;
		if (sample_evt)
			next_pcnt = 11'h000;
		else if (dm_tick)
			next_pcnt = pcnt + 11'h001;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			pcnt <= 11'h000;
			o_sample_tick <= 1'b0;
			o_mod_tick <= 1'b0;
			o_decim_factor <= 9'h000;
		end
		else
		begin
			pcnt <= next_pcnt;
			o_sample_tick <= sample_evt;
			o_mod_tick <= mod_evt;
			// RQ12 decimation factor by rate
			o_decim_factor <= `CFC_FACTOR_BASE << rate_eff;
		end
	end

	// Decimator integrators and combs, two input bits plus three times eight of growth
	logic signed [25:0] i1, i2, i3, d1, d2, d3, x, c1, c2, c3, scaled;
	logic signed [25:0] next_i1, next_i2, next_i3, next_d1, next_d2, next_d3;
	cfc_word_t next_adc;

	always_comb
	begin
		x = i_adc_mod_bit ? 26'sh0000001 : 26'sh3ffffff;
		// RQ16 sinc cubed integrate and comb
		next_i1 = mod_evt ? i1 + x : i1;
		next_i2 = mod_evt ? i2 + i1 : i2;
		next_i3 = mod_evt ? i3 + i2 : i3;
		c1 = i3 - d1;
		c2 = c1 - d2;
		c3 = c2 - d3;
		next_d1 = sample_evt ? i3 : d1;
		next_d2 = sample_evt ? c1 : d2;
		next_d3 = sample_evt ? c2 : d3;
		scaled = c3 >>> (3 * rate_eff);
		next_adc = o_adc_word;
		if (sample_evt)
			next_adc = (scaled > 26'sh0007fff) ? 16'h7fff : scaled[15:0];
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			i1 <= 26'sh0;
			i2 <= 26'sh0;
			i3 <= 26'sh0;
			d1 <= 26'sh0;
			d2 <= 26'sh0;
			d3 <= 26'sh0;
			o_adc_word <= 16'h0000;
		end
		else
		begin
			i1 <= next_i1;
			i2 <= next_i2;
			i3 <= next_i3;
			d1 <= next_d1;
			d2 <= next_d2;
			d3 <= next_d3;
			o_adc_word <= next_adc;
		end
	end

	// Output word shifter
	cfc_out_state_t ost, next_ost;
	logic pend, next_pend, next_sdo, next_ofs;
	cfc_word_t osh, next_osh;
	logic [3:0] obit, next_obit;

	always_comb
	begin
		next_ost = ost;
		next_osh = osh;
		next_obit = obit;
		next_sdo = o_sdo;
		next_ofs = o_output_frame_sync;
		next_pend = pend;
		if (rise)
		begin
			case (ost)
				CFC_OUT_IDLE:
				begin
					next_sdo = 1'b0;
					if (pend)
					begin
						// RQ17 sync one clock ahead
						next_ofs = 1'b1;
						next_osh = i_mode_mixed ? {1'b0, o_adc_word[15:1]} : o_adc_word;
						next_pend = 1'b0;
						next_ost = CFC_OUT_FS;
					end
				end
				CFC_OUT_FS:
				begin
					next_ofs = 1'b0;
					next_sdo = osh[15];
					next_osh = {osh[14:0], 1'b0};
					next_obit = `CFC_BIT_LAST;
					next_ost = CFC_OUT_SHIFT;
				end
				CFC_OUT_SHIFT:
				begin
					// RQ6 sixteen serial clocks per word
					if (obit == 4'h0)
					begin
						next_sdo = 1'b0;
						next_ost = CFC_OUT_IDLE;
					end
					else
					begin
						next_sdo = osh[15];
						next_osh = {osh[14:0], 1'b0};
						next_obit = obit - 4'h1;
					end
				end
				default:
					next_ost = CFC_OUT_IDLE;
			endcase
		end
		// New sample event wins over the take
		if (sample_evt)
			next_pend = 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ost <= CFC_OUT_IDLE;
			pend <= 1'b0;
			osh <= 16'h0000;
			obit <= 4'h0;
			o_sdo <= 1'b0;
			o_output_frame_sync <= 1'b0;
		end
		else
		begin
			ost <= next_ost;
			pend <= next_pend;
			osh <= next_osh;
			obit <= next_obit;
			o_sdo <= next_sdo;
			o_output_frame_sync <= next_ofs;
		end
	end

	// Input word shifter and frame counting
	logic [4:0] icnt, next_icnt;
	logic [14:0] ish, next_ish;
	logic [3:0] fidx, next_fidx;
	logic done;
	cfc_word_t w, next_dac, next_ctrl;
	logic next_dac_load, next_ctrl_valid;

	always_comb
	begin
		next_icnt = icnt;
		next_ish = ish;
		done = 1'b0;
		w = {ish, sdi_f};
		next_dac = o_dac_word;
		next_ctrl = o_ctrl_word;
		next_dac_load = 1'b0;
		next_ctrl_valid = 1'b0;
		if (fall)
		begin
			if (icnt != 5'h00)
			begin
				next_ish = w[14:0];
				next_icnt = icnt - 5'h01;
				done = (icnt == 5'h01);
			end
			// RQ17 sync accepted when idle or on last bit
			if (fs_f && (icnt <= 5'h01))
				next_icnt = `CFC_FRAME_BITS;
		end
		// RQ1 count saturates past eight
		next_fidx = fidx;
		if (done && (fidx != `CFC_FRAME_SAT))
			next_fidx = fidx + 4'h1;
		// RQ19 restart count each period
		if (sample_evt)
			next_fidx = {3'h0, done};
		if (done)
		begin
			if (!i_mode_data)
			begin
				next_ctrl = w;
				next_ctrl_valid = 1'b1;
			end
			// RQ2 RQ7 RQ10 position matches binary count
			else if (fidx == {1'b0, chain})
			begin
				if (i_mode_mixed && w[15])
				begin
					next_ctrl = w;
					next_ctrl_valid = 1'b1;
				end
				else
				begin
					next_dac = i_mode_mixed ? {w[14:0], 1'b0} : w;
					next_dac_load = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			icnt <= 5'h00;
			ish <= 15'h0000;
			fidx <= 4'h0;
			o_dac_word <= 16'h0000;
			o_ctrl_word <= 16'h0000;
			o_dac_load <= 1'b0;
			o_ctrl_valid <= 1'b0;
		end
		else
		begin
			icnt <= next_icnt;
			ish <= next_ish;
			fidx <= next_fidx;
			o_dac_word <= next_dac;
			o_ctrl_word <= next_ctrl;
			o_dac_load <= next_dac_load;
			o_ctrl_valid <= next_ctrl_valid;
		end
	end

	// Interpolator, linear ramp between samples at modulator rate
	cfc_word_t prev, next_prev;
	logic signed [24:0] acc, step, next_acc, next_step;
	logic signed [16:0] diff;
	cfc_word_t next_out;

	always_comb
	begin
		diff = $signed({o_dac_word[15], o_dac_word}) - $signed({prev[15], prev});
		next_prev = prev;
		next_acc = acc;
		next_step = step;
		next_out = o_dac_out;
		if (sample_evt)
		begin
			next_prev = o_dac_word;
			// RQ15 bypass takes sample directly
			if (i_interp_bypass)
			begin
				next_out = o_dac_word;
				next_step = 25'sh0;
				next_acc = $signed({o_dac_word[15], o_dac_word, 8'h00});
			end
			else
			begin
				// RQ13 ramp over factor modulator ticks
				// Sample event stands for the last tick, so land exactly on the old target
				next_out = prev;
				next_step = $signed({diff, 8'h00}) >>> sh;
				next_acc = $signed({prev[15], prev, 8'h00});
			end
		end
		else if (mod_evt)
		begin
			next_acc = acc + step;
			next_out = next_acc[23:8];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			prev <= 16'h0000;
			acc <= 25'sh0;
			step <= 25'sh0;
			o_dac_out <= 16'h0000;
		end
		else
		begin
			prev <= next_prev;
			acc <= next_acc;
			step <= next_step;
			o_dac_out <= next_out;
		end
	end
endmodule

// ---- sim/cfc_dsp_model.sv ----
// DSP serial port model that sends input frames and captures output words
`timescale 1ns/100ps
module cfc_dsp_model
(
	// Codec serial pins
	input wire logic i_sclk,
	input wire logic i_sdo,
	input wire logic i_ofs,
	output logic o_sdi,
	output logic o_ifs,
	// Last word shifted out by the codec
	output logic [15:0] o_rx
);
	initial
	begin
		o_sdi = 1'b0;
		o_ifs = 1'b0;
		o_rx = 16'h0000;
	end

	// sixteen bits follow the frame sync
	always @(posedge i_ofs)
	begin
		repeat (17) @(negedge i_sclk) o_rx = {o_rx[14:0], i_sdo};
	end

	// sync one clock ahead, or on the last bit back to back
	task automatic send(input int n, input logic [15:0] base);
		logic [15:0] w;
		if (n == 0)
			return;
		@(posedge i_sclk) #1 o_ifs = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			w = base + 16'h0101 * i[15:0];
			for (int b = 15; b >= 0; b--)
			begin
				@(posedge i_sclk) #1 o_sdi = w[b];
				o_ifs = (b == 0) && (i < n - 1);
			end
		end
		// Released data line shows the inverse of its last bit
		@(posedge i_sclk) #1 o_sdi = ~o_sdi;
	endtask
endmodule

// ---- sim/cfc_frame_counter_assertions.sv ----
// Port checker for the cascade frame counter
`timescale 1ns/100ps
module cfc_chk
(
	// Clock, reset and watched outputs
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic o_sclk,
	input wire logic o_sdo,
	input wire logic o_output_frame_sync,
	input wire logic o_dac_load,
	input wire logic o_ctrl_valid,
	input wire logic o_sample_tick,
	input wire logic o_mod_tick,
	input wire logic [8:0] o_decim_factor
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	a_sclk_half:
	assert property ($rose(o_sclk) |-> o_sclk [*4] ##1 !o_sclk)
	else $error("serial clock high time wrong");
	a_fs_one_sclk:
	assert property ($rose(o_output_frame_sync) |-> o_output_frame_sync [*8] ##1 !o_output_frame_sync)
	else $error("frame sync width wrong");
	a_fs_on_rise:
	assert property ($rose(o_output_frame_sync) |-> o_sclk && $past(o_sclk) && !$past(o_sclk, 2))
	else $error("frame sync off serial clock rise");
	a_fs_per_sample:
	assert property (o_sample_tick |-> ##[0:12] o_output_frame_sync)
	else $error("no frame sync after sample");
	a_sdo_quiet:
	assert property ($fell(o_output_frame_sync) |-> ##[128:129] !o_sdo)
	else $error("data line busy past sixteen bits");
	a_load_pulse:
	assert property (o_dac_load |=> !o_dac_load)
	else $error("dac load longer than one clock");
	a_ctrl_pulse:
	assert property (o_ctrl_valid |=> !o_ctrl_valid)
	else $error("control valid longer than one clock");
	a_mod_spacing:
	assert property (o_mod_tick |=> (!o_mod_tick) [*7])
	else $error("modulator ticks too close");
	a_sample_spacing:
	assert property (o_sample_tick |=> (!o_sample_tick) [*8])
	else $error("sample ticks too close");
	a_factor_set:
	assert property (!$past(i_srst) |-> o_decim_factor inside {9'h020, 9'h040, 9'h080, 9'h100})
	else $error("decimation factor out of set");

	// Main traffic
	c_load: cover property (o_dac_load);
	c_ctrl: cover property (o_ctrl_valid);
	c_fs: cover property ($rose(o_output_frame_sync));
endmodule

bind cfc_frame_counter cfc_chk chk (.i_clk(i_clk), .i_srst(i_srst), .o_sclk(o_sclk),
	.o_sdo(o_sdo), .o_output_frame_sync(o_output_frame_sync), .o_dac_load(o_dac_load),
	.o_ctrl_valid(o_ctrl_valid), .o_sample_tick(o_sample_tick), .o_mod_tick(o_mod_tick),
	.o_decim_factor(o_decim_factor));

// ---- sim/testbench.sv ----
// Self-checking bench for the cascade frame counter
`timescale 1ns/100ps
module testbench;
	import cfc_pkg::*;
	logic i_clk, i_srst, i_chain_length_we, i_rate_we, i_mclk_div_we, sdi, ifs, ofs;
	logic i_mode_data, i_mode_mixed, i_interp_bypass, i_adc_mod_bit;
	logic o_sclk, o_sdo, o_dac_load, o_ctrl_valid, o_sample_tick;
	cfc_count_t i_chain_length_field, i_mclk_div_code;
	cfc_rate_t i_rate_sel;
	cfc_word_t o_dac_word, o_ctrl_word, o_adc_word, last_dac, last_ctrl, rx, dac_out;
	logic [8:0] o_decim_factor;
	logic [3:0] pat = 4'h0;
	int n_errors, checked, n_load, n_ctrl, gap;

	cfc_frame_counter dut (.i_clk(i_clk), .i_srst(i_srst),
		.i_chain_length_field(i_chain_length_field), .i_chain_length_we(i_chain_length_we),
		.i_rate_sel(i_rate_sel), .i_rate_we(i_rate_we), .i_mclk_div_code(i_mclk_div_code),
		.i_mclk_div_we(i_mclk_div_we), .i_mode_data(i_mode_data), .i_mode_mixed(i_mode_mixed),
		.i_interp_bypass(i_interp_bypass), .i_adc_mod_bit(i_adc_mod_bit), .i_sdi(sdi),
		.i_input_frame_sync(ifs), .o_sclk(o_sclk), .o_sdo(o_sdo), .o_output_frame_sync(ofs),
		.o_dac_word(o_dac_word), .o_dac_load(o_dac_load), .o_ctrl_word(o_ctrl_word),
		.o_ctrl_valid(o_ctrl_valid), .o_adc_word(o_adc_word), .o_dac_out(dac_out),
		.o_sample_tick(o_sample_tick), .o_mod_tick(), .o_decim_factor(o_decim_factor));
	cfc_dsp_model dsp (.i_sclk(o_sclk), .i_sdo(o_sdo), .i_ofs(ofs), .o_sdi(sdi), .o_ifs(ifs),
		.o_rx(rx));

	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// Tally received words
	always @(posedge i_clk)
	begin
		if (o_dac_load === 1'b1)
		begin
			n_load++;
			last_dac = o_dac_word;
		end
		if (o_ctrl_valid === 1'b1)
		begin
			n_ctrl++;
			last_ctrl = o_ctrl_word;
		end
	end

	// Modulator bit pattern
	always @(negedge i_clk)
	begin
		pat <= pat + 4'h3;
		i_adc_mod_bit <= pat[3];
	end

	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic cfg(input cfc_count_t c, input cfc_rate_t r, input logic d, input logic m);
		@(negedge i_clk);
		i_chain_length_field = c;
		i_chain_length_we = 1'b1;
		i_rate_sel = r;
		i_rate_we = 1'b1;
		@(negedge i_clk);
		i_chain_length_we = 1'b0;
		i_rate_we = 1'b0;
		i_mode_data = d;
		i_mode_mixed = m;
	endtask

	task automatic div(input cfc_count_t code);
		@(negedge i_clk);
		i_mclk_div_code = code;
		i_mclk_div_we = 1'b1;
		@(negedge i_clk);
		i_mclk_div_we = 1'b0;
	endtask

	// Clocks between two sample events, second gap after any change
	task automatic measure();
		@(posedge i_clk iff o_sample_tick === 1'b1);
		repeat (2)
		begin
			gap = 0;
			do
			begin
				@(posedge i_clk);
				gap++;
			end
			while (o_sample_tick !== 1'b1 && gap < 5000);
		end
	endtask

	// Send n words in the next sample period
	task automatic frame(input int n, input cfc_word_t base);
		@(posedge ofs);
		n_load = 0;
		n_ctrl = 0;
		dsp.send(n, base);
		repeat (16) @(posedge i_clk);
	endtask

	task automatic t_chain(input cfc_count_t c);
		cfg(c, 2'h3, 1'b1, 1'b0);
		frame(8, 16'h1000);
		chk(n_load == 1 && last_dac === 16'h1000 + 16'h0101 * c, "dac word by position");
		chk(rx === o_adc_word, "output word");
		frame(8, 16'h2000);
		chk(n_load == 1 && last_dac === 16'h2000 + 16'h0101 * c, "second period");
		frame(c, 16'h3000);
		chk(n_load == 0, "short chain loaded");
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (99000) @(posedge i_clk);
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		{i_srst, i_chain_length_we, i_rate_we, i_mclk_div_we} = 4'he;
		{i_mode_data, i_mode_mixed, i_interp_bypass} = 3'h0;
		i_chain_length_field = 3'h0;
		i_mclk_div_code = 3'h0;
		i_rate_sel = 2'h0;
		n_errors = 0;
		checked = 0;
		repeat (5) @(negedge i_clk);
		{i_srst, i_chain_length_we, i_rate_we} = 3'h0;
		measure();
		chk(gap == 2048 && o_decim_factor === 9'h100, "default rate");
		for (int r = 0; r < 4; r++)
		begin
			cfg(3'h0, r[1:0], 1'b0, 1'b0);
			measure();
			chk(gap == (256 << r) && o_decim_factor === (9'h020 << r), "rate");
		end
		cfg(3'h0, 2'h0, 1'b0, 1'b0);
		div(3'h1);
		measure();
		chk(gap == 512, "divided rate");
		div(3'h0);
		for (int c = 0; c < 8; c++)
			t_chain(c[2:0]);
		cfg(3'h1, 2'h3, 1'b1, 1'b1);
		frame(2, 16'h1234);
		chk(n_load == 1 && last_dac === 16'h266a && rx[15] === 1'b0, "mixed data");
		frame(2, 16'h8000);
		chk(n_load == 0 && n_ctrl == 1 && last_ctrl === 16'h8101, "mixed control");
		chk(dac_out > 16'h266a && dac_out < 16'h2707, "interpolated ramp");
		@(negedge i_clk);
		i_interp_bypass = 1'b1;
		frame(2, 16'h0800);
		chk(n_load == 1 && last_dac === 16'h1202, "mixed data again");
		cfg(3'h0, 2'h3, 1'b0, 1'b0);
		frame(3, 16'h4000);
		chk(n_load == 0 && n_ctrl == 3 && last_ctrl === 16'h4202, "program words");
		chk(dac_out === 16'h1202, "bypass output");
		report_and_stop();
	end
endmodule
